// [cfs_pkg.sv]
// Package for the command frame completion sequencer: states, constants, carriers
package cfs_pkg;

    // Slot geometry
    localparam int unsigned SLOT_COUNT = 32;
    localparam int unsigned SLOT_W     = 5;
    localparam int unsigned CCC_W      = 8;

    // Reset values
    localparam logic [SLOT_COUNT-1:0] RST_ISSUE_BITS = 32'h0000_0000;
    localparam logic [CCC_W-1:0]      RST_CCC        = 8'h00;

    // Register map of the plain register port
    localparam logic [3:0] OFS_CTRL    = 4'h0;
    localparam logic [3:0] OFS_ISSUE   = 4'h1;
    localparam logic [3:0] OFS_QACTIVE = 4'h2;
    localparam logic [3:0] OFS_STATUS  = 4'h3;
    localparam logic [3:0] OFS_CCC     = 4'h4;

    // Control register field positions
    localparam int unsigned CTRL_FBS_BIT   = 0;
    localparam int unsigned CTRL_CCC_BIT   = 1;
    localparam int unsigned CTRL_HONOR_BIT = 2;

    // Fetch lengths picked by this implementation
    localparam logic [4:0] PKT_FETCH_BYTES  = 5'h10;
    localparam logic [3:0] DESC_FETCH_COUNT = 4'h4;
    localparam logic [7:0] DATA_FETCH_WORDS = 8'h10;

    // Sequencer states, gray coded along the main path
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_SUCCESS   = 4'h1,
        ST_CLEAR_CI  = 4'h3,
        ST_CCC       = 4'h2,
        ST_PM_AGGR   = 4'h6,
        ST_PF_PKT    = 4'h7,
        ST_PF_DESC   = 4'h5,
        ST_PF_DATA   = 4'h4,
        ST_BIST      = 4'hc,
        ST_FB_IDLE   = 4'hd,
        ST_P_IDLE    = 4'hf
    } cfs_state_t;

    // Command flags of the issued slot, from header and table
    typedef struct packed {
        logic bist;
        logic clear_busy;
        logic packet;
        logic prefetchable;
        logic write_dir;
    } cfs_cmd_flags_t;

    // Prefetch request toward the fetch engine
    typedef struct packed {
        logic             pkt;
        logic             desc;
        logic             data;
        logic [SLOT_W-1:0] slot;
        logic [7:0]       amount;
    } cfs_fetch_t;

endpackage : cfs_pkg

// [cfs_seq.sv]
// Command frame completion sequencer for one port
module cfs_seq (
    // Clock and reset
    input  wire logic                            i_clk,
    input  wire logic                            i_reset,
    // Register port
    input  wire logic [3:0]                      i_reg_addr,
    input  wire logic [31:0]                     i_reg_wdata,
    input  wire logic                            i_reg_wr,
    input  wire logic                            i_reg_rd,
    output logic      [31:0]                     o_reg_rdata,
    // Command transfer handoff
    input  wire logic                            i_cfis_ok,
    input  wire logic [cfs_pkg::SLOT_W-1:0]      i_issued_slot_index,
    input  wire cfs_pkg::cfs_cmd_flags_t         i_flags,
    input  wire logic                            i_taskfile_busy_set,
    // Sequencer outputs
    output logic                                 o_pending_command_flag,
    output logic                                 o_taskfile_busy_bit,
    output cfs_pkg::cfs_state_t                  o_state,
    output logic                                 o_bist_ongoing,
    output logic                                 o_pm_aggr,
    output logic                                 o_idle_fb,
    output logic                                 o_idle_port,
    output cfs_pkg::cfs_fetch_t                  o_fetch
);

    ////////////////////////////////////////////////////////////////////////////
    // State declarations
    cfs_pkg::cfs_state_t                 state_ff,     nxt_state;
    cfs_pkg::cfs_cmd_flags_t             flags_ff,     nxt_flags;
    logic [cfs_pkg::SLOT_W-1:0]          slot_ff,      nxt_slot;
    logic                                pend_ff,      nxt_pend;
    logic                                busy_ff,      nxt_busy;
    logic [cfs_pkg::SLOT_COUNT-1:0]      issue_ff,     nxt_issue;
    logic [cfs_pkg::SLOT_COUNT-1:0]      qact_ff,      nxt_qact;
    logic [cfs_pkg::CCC_W-1:0]           ccc_ff,       nxt_ccc;
    logic                                fbs_en_ff,    nxt_fbs_en;
    logic                                ccc_sel_ff,   nxt_ccc_sel;
    logic                                honor_ff,     nxt_honor;
    logic [31:0]                         rdata_ff,     nxt_rdata;
    cfs_pkg::cfs_fetch_t                 fetch_ff,     nxt_fetch;
    logic                                pf_ok;
    cfs_pkg::cfs_state_t                 idle_target;
    logic [cfs_pkg::SLOT_COUNT-1:0]      issue_clr;
    logic                                bist_ff,      nxt_bist;
    logic                                pm_ff,        nxt_pm;
    logic                                idle_fb_ff,   nxt_idle_fb;
    logic                                idle_port_ff, nxt_idle_port;

    // Prefetchable flag, only honoured when software asks for it
    assign pf_ok       = flags_ff.prefetchable & honor_ff;
    assign idle_target = fbs_en_ff ? cfs_pkg::ST_FB_IDLE : cfs_pkg::ST_P_IDLE;

    // State decodes taken from the next state so the outputs come from flops
    assign nxt_bist      = (nxt_state == cfs_pkg::ST_BIST);
    assign nxt_pm        = (nxt_state == cfs_pkg::ST_PM_AGGR);
    assign nxt_idle_fb   = (nxt_state == cfs_pkg::ST_FB_IDLE);
    assign nxt_idle_port = (nxt_state == cfs_pkg::ST_P_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Per-slot issue bit clear decode
    for (genvar g = 0; g < cfs_pkg::SLOT_COUNT; g++) begin : g_clr
        assign issue_clr[g] = (state_ff == cfs_pkg::ST_CLEAR_CI) && (slot_ff == cfs_pkg::SLOT_W'(g));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer next state
    always_comb begin
        nxt_state = state_ff;
        nxt_flags = flags_ff;
        nxt_slot  = slot_ff;
        nxt_pend  = pend_ff;
        nxt_busy  = busy_ff | i_taskfile_busy_set;
        nxt_ccc   = ccc_ff;
        nxt_fetch = '0;
        unique case (state_ff)
            cfs_pkg::ST_IDLE, cfs_pkg::ST_FB_IDLE, cfs_pkg::ST_P_IDLE,
            cfs_pkg::ST_PM_AGGR, cfs_pkg::ST_BIST: begin
                // Idle-like states wait here; outer logic owns the exit
                if (i_cfis_ok) begin
                    nxt_flags = i_flags;
                    nxt_slot  = i_issued_slot_index;
                    nxt_pend  = 1'b1;
                    nxt_state = cfs_pkg::ST_SUCCESS;
                end
            end
            cfs_pkg::ST_SUCCESS: begin
                nxt_pend = 1'b0;
                if (flags_ff.bist) begin
                    nxt_state = cfs_pkg::ST_BIST;
                end else if (flags_ff.clear_busy) begin
                    nxt_state = cfs_pkg::ST_CLEAR_CI;
                end else if (flags_ff.packet && pf_ok) begin
                    nxt_state = cfs_pkg::ST_PF_PKT;
                end else if (pf_ok) begin
                    nxt_state = cfs_pkg::ST_PF_DESC;
                end else begin
                    nxt_state = idle_target;
                end
            end
            cfs_pkg::ST_CLEAR_CI: begin
                // Byte count is deliberately not touched here, no data could move
                nxt_busy = i_taskfile_busy_set;
                if (ccc_sel_ff && !qact_ff[slot_ff]) begin
                    nxt_state = cfs_pkg::ST_CCC;
                end else begin
                    nxt_state = cfs_pkg::ST_PM_AGGR;
                end
            end
            cfs_pkg::ST_CCC: begin
                nxt_ccc   = ccc_ff + 8'h01;
                nxt_state = cfs_pkg::ST_PM_AGGR;
            end
            cfs_pkg::ST_PF_PKT: begin
                nxt_fetch.pkt    = 1'b1;
                nxt_fetch.slot   = slot_ff;
                nxt_fetch.amount = {3'h0, cfs_pkg::PKT_FETCH_BYTES};
                nxt_state        = pf_ok ? cfs_pkg::ST_PF_DESC : idle_target;
            end
            cfs_pkg::ST_PF_DESC: begin
                nxt_fetch.desc   = 1'b1;
                nxt_fetch.slot   = slot_ff;
                nxt_fetch.amount = {4'h0, cfs_pkg::DESC_FETCH_COUNT};
                nxt_state        = flags_ff.write_dir ? cfs_pkg::ST_PF_DATA : idle_target;
            end
            cfs_pkg::ST_PF_DATA: begin
                nxt_fetch.data   = 1'b1;
                nxt_fetch.slot   = slot_ff;
                nxt_fetch.amount = cfs_pkg::DATA_FETCH_WORDS;
                nxt_state        = idle_target;
            end
            default: begin
                nxt_state = cfs_pkg::ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port next values; hardware clears win over software sets
    always_comb begin
        nxt_fbs_en  = fbs_en_ff;
        nxt_ccc_sel = ccc_sel_ff;
        nxt_honor   = honor_ff;
        nxt_issue   = issue_ff;
        nxt_qact    = qact_ff;
        nxt_rdata   = 32'h0000_0000;
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                cfs_pkg::OFS_CTRL: begin
                    nxt_fbs_en  = i_reg_wdata[cfs_pkg::CTRL_FBS_BIT];
                    nxt_ccc_sel = i_reg_wdata[cfs_pkg::CTRL_CCC_BIT];
                    nxt_honor   = i_reg_wdata[cfs_pkg::CTRL_HONOR_BIT];
                end
                cfs_pkg::OFS_ISSUE: begin
                    nxt_issue = issue_ff | i_reg_wdata; // Set only, hardware clears
                end
                cfs_pkg::OFS_QACTIVE: begin
                    nxt_qact = i_reg_wdata;
                end
                default: begin
                end
            endcase
        end
        nxt_issue = nxt_issue & ~issue_clr;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                cfs_pkg::OFS_CTRL:    nxt_rdata = {29'h0, honor_ff, ccc_sel_ff, fbs_en_ff};
                cfs_pkg::OFS_ISSUE:   nxt_rdata = issue_ff;
                cfs_pkg::OFS_QACTIVE: nxt_rdata = qact_ff;
                cfs_pkg::OFS_STATUS:  nxt_rdata = {23'h0, slot_ff, busy_ff, pend_ff, 2'h0} | {28'h0, state_ff};
                cfs_pkg::OFS_CCC:     nxt_rdata = {24'h0, ccc_ff};
                default:              nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            state_ff   <= cfs_pkg::ST_IDLE;
            flags_ff   <= '0;
            slot_ff    <= '0;
            pend_ff    <= 1'b0;
            busy_ff    <= 1'b0;
            issue_ff   <= cfs_pkg::RST_ISSUE_BITS;
            qact_ff    <= cfs_pkg::RST_ISSUE_BITS;
            ccc_ff     <= cfs_pkg::RST_CCC;
            fbs_en_ff  <= 1'b0;
            ccc_sel_ff <= 1'b0;
            honor_ff   <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            fetch_ff   <= '0;
            bist_ff      <= 1'b0;
            pm_ff        <= 1'b0;
            idle_fb_ff   <= 1'b0;
            idle_port_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            flags_ff   <= nxt_flags;
            slot_ff    <= nxt_slot;
            pend_ff    <= nxt_pend;
            busy_ff    <= nxt_busy;
            issue_ff   <= nxt_issue;
            qact_ff    <= nxt_qact;
            ccc_ff     <= nxt_ccc;
            fbs_en_ff  <= nxt_fbs_en;
            ccc_sel_ff <= nxt_ccc_sel;
            honor_ff   <= nxt_honor;
            rdata_ff   <= nxt_rdata;
            fetch_ff   <= nxt_fetch;
            bist_ff      <= nxt_bist;
            pm_ff        <= nxt_pm;
            idle_fb_ff   <= nxt_idle_fb;
            idle_port_ff <= nxt_idle_port;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops, decodes included
    assign o_reg_rdata            = rdata_ff;
    assign o_pending_command_flag = pend_ff;
    assign o_taskfile_busy_bit    = busy_ff;
    assign o_state                = state_ff;
    assign o_bist_ongoing         = bist_ff;
    assign o_pm_aggr              = pm_ff;
    assign o_idle_fb              = idle_fb_ff;
    assign o_idle_port            = idle_port_ff;
    assign o_fetch                = fetch_ff;

endmodule // cfs_seq

// [cfs_seq_asserts.sv]
// Port relations of the completion sequencer, bound to its top module
module cfs_seq_chk (
    input wire logic                    i_clk,
    input wire logic                    i_reset,
    input wire logic                    i_reg_rd,
    input wire logic [31:0]             o_reg_rdata,
    input wire logic                    i_cfis_ok,
    input wire cfs_pkg::cfs_cmd_flags_t i_flags,
    input wire logic                    i_taskfile_busy_set,
    input wire logic                    o_pending_command_flag,
    input wire logic                    o_taskfile_busy_bit,
    input wire cfs_pkg::cfs_state_t     o_state,
    input wire cfs_pkg::cfs_fetch_t     o_fetch
);
    // Only resting states take a new handoff, so the three handoff checks are gated on them
    logic idle_like;
    assign idle_like = o_state inside {cfs_pkg::ST_IDLE, cfs_pkg::ST_FB_IDLE, cfs_pkg::ST_P_IDLE,
                                       cfs_pkg::ST_PM_AGGR, cfs_pkg::ST_BIST};
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    ok_pend_a: assert property (i_cfis_ok && idle_like |=> o_pending_command_flag && o_state == cfs_pkg::ST_SUCCESS)
        else $error("pending flag or success state missing");
    pend_drop_a: assert property (o_state == cfs_pkg::ST_SUCCESS |=> !o_pending_command_flag)
        else $error("pending flag not cleared");
    bist_first_a: assert property (i_cfis_ok && idle_like && i_flags.bist |=> ##1 o_state == cfs_pkg::ST_BIST)
        else $error("self-test branch not taken");
    early_done_a: assert property (i_cfis_ok && idle_like && !i_flags.bist && i_flags.clear_busy |=> ##1 o_state == cfs_pkg::ST_CLEAR_CI)
        else $error("early completion branch not taken");
    busy_clear_a: assert property (o_state == cfs_pkg::ST_CLEAR_CI && !i_taskfile_busy_set |=> !o_taskfile_busy_bit)
        else $error("busy bit not cleared");
    after_clear_a: assert property (o_state == cfs_pkg::ST_CLEAR_CI |=> o_state inside {cfs_pkg::ST_CCC, cfs_pkg::ST_PM_AGGR})
        else $error("wrong state after early completion");
    ccc_next_a: assert property (o_state == cfs_pkg::ST_CCC |=> o_state == cfs_pkg::ST_PM_AGGR)
        else $error("coalescing count not followed by power state");
    desc_fetch_a: assert property (o_state == cfs_pkg::ST_PF_DESC |=> o_fetch.desc && o_fetch.amount == {4'h0, cfs_pkg::DESC_FETCH_COUNT})
        else $error("descriptor fetch pulse missing");
    data_idle_a: assert property (o_state == cfs_pkg::ST_PF_DATA |=> o_state inside {cfs_pkg::ST_FB_IDLE, cfs_pkg::ST_P_IDLE})
        else $error("data prefetch not followed by idle");
    rdata_zero_a: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
endmodule // cfs_seq_chk

bind cfs_seq cfs_seq_chk cfs_seq_chk_i (.i_clk(i_clk), .i_reset(i_reset), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .i_cfis_ok(i_cfis_ok), .i_flags(i_flags), .i_taskfile_busy_set(i_taskfile_busy_set),
    .o_pending_command_flag(o_pending_command_flag), .o_taskfile_busy_bit(o_taskfile_busy_bit),
    .o_state(o_state), .o_fetch(o_fetch));

// [cfs_drive_model.sv]
// Far-side drive: acknowledges a sent command frame after a chosen delay
module cfs_drive_model (
    input  wire logic                    i_clk,
    input  wire logic                    i_go,
    input  wire logic [3:0]              i_delay,
    input  wire logic [4:0]              i_slot,
    input  wire cfs_pkg::cfs_cmd_flags_t i_flags,
    output logic                         o_ok,
    output logic [4:0]                   o_slot,
    output cfs_pkg::cfs_cmd_flags_t      o_flags
);
    logic [4:0]              cnt_ff;
    logic [4:0]              slot_ff;
    cfs_pkg::cfs_cmd_flags_t flags_ff;
    // Slot and flags toggle outside the pulse so a late sample never looks valid
    initial begin
        cnt_ff = 5'h00;
        o_ok = 1'b0;
        o_slot = 5'h00;
        o_flags = '0;
    end
    always @(posedge i_clk) begin
        if (i_go) begin
            cnt_ff <= {1'b0, i_delay} + 5'h01;
            slot_ff <= i_slot;
            flags_ff <= i_flags;
        end else if (cnt_ff != 5'h00) begin
            cnt_ff <= cnt_ff - 5'h01;
        end
        o_ok <= (cnt_ff == 5'h01);
        o_slot <= (cnt_ff == 5'h01) ? slot_ff : ~o_slot;
        o_flags <= (cnt_ff == 5'h01) ? flags_ff : ~o_flags;
    end
endmodule // cfs_drive_model

// [cfs_seq_tb.sv]
// Self-checking bench of the completion sequencer against a queue model
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module cfs_seq_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                    i_clk, i_reset, wr, rd, bset, go, ok, pend, busy;
    logic                    bist, pm, ifb, ip;
    logic [3:0]              addr, dly;
    logic [31:0]             wdata, rdata, issue, qact, ctrl, r;
    logic [4:0]              ps, slot;
    cfs_pkg::cfs_cmd_flags_t pf, fl;
    cfs_pkg::cfs_state_t     st;
    cfs_pkg::cfs_fetch_t     fetch;
    int                      errors, tests_run, seed, ccc, k;
    cfs_seq cfs_seq_i (.i_clk(i_clk), .i_reset(i_reset), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .i_cfis_ok(ok), .i_issued_slot_index(slot), .i_flags(fl),
        .i_taskfile_busy_set(bset), .o_pending_command_flag(pend), .o_taskfile_busy_bit(busy), .o_state(st),
        .o_bist_ongoing(bist), .o_pm_aggr(pm), .o_idle_fb(ifb), .o_idle_port(ip), .o_fetch(fetch));
    cfs_drive_model cfs_drive_model_i (.i_clk(i_clk), .i_go(go), .i_delay(dly), .i_slot(ps), .i_flags(pf),
        .o_ok(ok), .o_slot(slot), .o_flags(fl));
    // Free-running 250 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Register strobes last one cycle; a gap cycle keeps two tasks from touching a strobe at one edge
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    // One handoff: the model queue holds every state expected after the acknowledge
    task automatic run_cmd;
        cfs_pkg::cfs_state_t     q[$];
        logic [4:0]              s;
        cfs_pkg::cfs_cmd_flags_t f;
        cfs_pkg::cfs_state_t     prev;
        int                      i;
        s = 5'($random(seed));
        f = 5'($random(seed));
        q = {cfs_pkg::ST_SUCCESS};
        if (f.bist) q.push_back(cfs_pkg::ST_BIST);
        else if (f.clear_busy) begin
            q.push_back(cfs_pkg::ST_CLEAR_CI);
            if (ctrl[1] && !qact[s]) begin
                q.push_back(cfs_pkg::ST_CCC);
                ccc++;
            end
            q.push_back(cfs_pkg::ST_PM_AGGR);
            issue[s] = 1'b0;
        end else begin
            if (ctrl[2] && f.prefetchable) begin
                if (f.packet) q.push_back(cfs_pkg::ST_PF_PKT);
                q.push_back(cfs_pkg::ST_PF_DESC);
                if (f.write_dir) q.push_back(cfs_pkg::ST_PF_DATA);
            end
            q.push_back(ctrl[0] ? cfs_pkg::ST_FB_IDLE : cfs_pkg::ST_P_IDLE);
        end
        @(posedge i_clk);
        go <= 1'b1;
        bset <= 1'b1;
        ps <= s;
        pf <= f;
        dly <= ($random(seed) & 1) ? 4'h0 : 4'h9;
        @(posedge i_clk);
        go <= 1'b0;
        bset <= 1'b0;
        for (i = 0; i < 40 && ok !== 1'b1; i++) @(posedge i_clk);
        if (i == 40) begin
            errors++;
            wrap_up();
        end
        prev = cfs_pkg::ST_IDLE;
        foreach (q[j]) begin
            #1 `CHK("state", q[j], st)
            if (j == 0) `CHK("pending", 1'b1, pend)
            `CHK("bist flag", q[j] == cfs_pkg::ST_BIST, bist)
            `CHK("power flag", q[j] == cfs_pkg::ST_PM_AGGR, pm)
            `CHK("idle flags", {q[j] == cfs_pkg::ST_FB_IDLE, q[j] == cfs_pkg::ST_P_IDLE}, {ifb, ip})
            `CHK("fetch pkt", prev == cfs_pkg::ST_PF_PKT, fetch.pkt)
            `CHK("fetch desc", prev == cfs_pkg::ST_PF_DESC, fetch.desc)
            `CHK("fetch data", prev == cfs_pkg::ST_PF_DATA, fetch.data)
            `CHK("fetch slot", (prev inside {cfs_pkg::ST_PF_PKT, cfs_pkg::ST_PF_DESC, cfs_pkg::ST_PF_DATA}) ? s : 5'h00, fetch.slot)
            prev = q[j];
            @(posedge i_clk);
        end
        #1 `CHK("busy", (!f.bist && f.clear_busy) ? 1'b0 : 1'b1, busy)
        $display("command done slot %0d flags %0h", s, f);
    endtask
    // Eight control settings, six random handoffs each, registers checked after every batch
    initial begin
        {wr, rd, bset, go, addr, dly, wdata, ps, pf} = '0;
        {errors, tests_run, ccc} = '0;
        {issue, qact} = '0;
        seed = 56938;
        i_reset = 1'b1;
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        reg_rd(cfs_pkg::OFS_CCC, r);
        `CHK("ccc reset", {24'h0, cfs_pkg::RST_CCC}, r)
        for (k = 0; k < 8; k++) begin
            ctrl = 32'(k);
            reg_wr(cfs_pkg::OFS_CTRL, ctrl);
            qact = $random(seed);
            reg_wr(cfs_pkg::OFS_QACTIVE, qact);
            r = $random(seed);
            issue |= r;
            reg_wr(cfs_pkg::OFS_ISSUE, r);
            repeat (6) run_cmd();
            reg_rd(cfs_pkg::OFS_ISSUE, r);
            `CHK("issue", issue, r)
            reg_rd(cfs_pkg::OFS_CCC, r);
            `CHK("ccc", {24'h0, 8'(ccc)}, r)
            reg_rd(4'h9, r);
            `CHK("unmapped", 32'h0000_0000, r)
            $display("batch %0d done", k);
        end
        wrap_up();
    end
endmodule // cfs_seq_tb
